// File: core/hbdma_pkg.sv
// constants, state type and state record of the host bus interrupt and dma master
// assumes a 100 MHz core clock; all users reference names through the package scope
package hbdma_pkg;
	// timing
	localparam int CLK_NS = 10;
	localparam int STEP_NS = 110;
	localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);
	localparam int TMO_NS = 39000;
	localparam int TMO_CYC = TMO_NS / CLK_NS;
	localparam logic [11:0] TMO_LAST = 12'(TMO_CYC - 1);
	// step numbers of the timing chain, one step per 110 ns
	localparam logic [2:0] STEP_SYNC = 3'h3;
	localparam logic [2:0] STEP_DATA = 3'h4;
	localparam logic [2:0] STEP_STRB = 3'h5;
	// local ports and their bits
	localparam logic [7:0] PORT1_ADDR = 8'h01;
	localparam logic [7:0] PORT2_ADDR = 8'h02;
	localparam int P1_IRQA = 0;
	localparam int P1_BUSY = 2;
	localparam int P2_UPPER = 0;
	localparam int P2_BS7 = 3;
	localparam int P2_IRQB = 4;
	// host status word bits
	localparam int HSW_IRQA = 8;
	localparam int HSW_IRQB = 9;
	// vectors, locations 300 and 304 octal
	localparam logic [15:0] VEC_A = 16'h00c0;
	localparam logic [15:0] VEC_B = 16'h00c4;
	localparam int VEC_SEL_BIT = 2;
	// window: local addresses 8000-ffff
	localparam int WIN_BIT = 15;
	// positions inside the synchronised input vector
	localparam int I_MREQ = 0;
	localparam int I_MWR = 1;
	localparam int I_SYNC = 2;
	localparam int I_RPLY = 3;
	localparam int I_DIN = 4;
	localparam int I_BIAKI = 5;
	localparam int I_DMGI = 6;
	localparam int I_ADDR = 7;
	localparam int I_WD = 23;
	localparam int I_DAL = 31;
	localparam int IN_W = 47;

	typedef enum logic [3:0] {
		ST_IDLE, ST_REQ, ST_WAITBUS, ST_STEP, ST_WAITRPLY,
		ST_HOLD, ST_WAITRN, ST_RESET, ST_FORCED
	} hbdma_state_e;

	typedef struct packed {
		hbdma_state_e state;
		logic [IN_W-1:0] s1;
		logic [IN_W-1:0] s2;
		logic irqA;
		logic irqB;
		logic upper;
		logic bs7;
		logic [7:0] portRdata;
		logic ready;
		logic winHit;
		logic local_memory_request;
		logic sack;
		logic dmgo;
		logic biako;
		logic birq;
		logic sync;
		logic din;
		logic dout;
		logic wtbt;
		logic addrEn;
		logic bs7Oe;
		logic dataEn;
		logic forced;
		logic vecDrive;
		logic vecRply;
		logic lvlBSel;
		logic isWrite;
		logic tmoRun;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [15:0] dalOut;
		logic dalOe;
		logic [15:0] hsw;
		logic [3:0] stepCnt;
		logic [2:0] step;
		logic [11:0] tmo;
	} hbdma_st_s;
endpackage

// File: core/hbdma_bridge.sv
// host bus interrupt requester and single-byte dma master for a local 8-bit processor
// assumes open-drain host lines resolved outside; an oe output high asserts that line
//
// What this block does
// - two request levels, vectors 300 and 304
// - port1 bit0 and port2 bit4 drive requests
// - both requests readable by host and local
// - any pending request asserts birq
// - acknowledge: drop birq, drive vector, reply
// - vector line two selects level b
// - upper local half starts dma cycle
// - host a0-14 local, a15 from port2
// - port2 bit3 drives bs7 at address
// - one byte, local a0 picks lane
// - processor waits during dma cycle
// - request dma, latch grant, stop passing it
// - wait sync and reply idle, then sack
// - step chain: address, sync 330, off 440
// - write data 440, dout 550; read din
// - reply frees processor; request drop ends strobe
// - reply trailing edge times release at r110
// - 39 us timeout forces a reply
// - request drop clears forced reply, resets
`timescale 1ns/1ps
module hbdma_bridge (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// local port bus, same clock
	input wire logic [7:0] portAddr,
	input wire logic [7:0] portWdata,
	input wire logic portWr,
	input wire logic portRd,
	output logic [7:0] portRdata,
	// local memory bus
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memWdata,
	input wire logic memReq,
	input wire logic memWrite,
	output logic [7:0] memRdata,
	output logic localReady,
	// host bus received levels
	input wire logic [15:0] hostDalIn,
	input wire logic hostSyncIn,
	input wire logic hostRplyIn,
	input wire logic hostDinIn,
	input wire logic hostBiakiIn,
	input wire logic hostDmgiIn,
	// host bus drives
	output logic [15:0] hostDalOut,
	output logic hostDalOe,
	output logic hostBirqOe,
	output logic hostBiakoOut,
	output logic hostDmgoOut,
	output logic hostDmrOe,
	output logic hostSackOe,
	output logic hostSyncOe,
	output logic hostDinOe,
	output logic hostDoutOe,
	output logic hostWtbtOe,
	output logic hostBs7Oe,
	output logic hostRplyOe,
	// status
	output logic vectorDrive,
	output logic levelBVectorSelect,
	output logic dmaWindowHit,
	output logic forcedReply,
	output logic [15:0] hostStatusWord0
);
	hbdma_pkg::hbdma_st_s st_r;
	hbdma_pkg::hbdma_st_s st_nxt;
	logic [hbdma_pkg::IN_W-1:0] inVec;
	logic mreqS;
	logic mwrS;
	logic syncS;
	logic rplyS;
	logic dinS;
	logic biakiS;
	logic dmgiS;
	logic [15:0] addrS;
	logic [7:0] wdS;
	logic [15:0] dalS;
	logic pend;

	assign inVec = {hostDalIn, memWdata, memAddr, hostDmgiIn, hostBiakiIn,
		hostDinIn, hostRplyIn, hostSyncIn, memWrite, memReq};
	assign mreqS = st_r.s2[hbdma_pkg::I_MREQ];
	assign mwrS = st_r.s2[hbdma_pkg::I_MWR];
	assign syncS = st_r.s2[hbdma_pkg::I_SYNC];
	assign rplyS = st_r.s2[hbdma_pkg::I_RPLY];
	assign dinS = st_r.s2[hbdma_pkg::I_DIN];
	assign biakiS = st_r.s2[hbdma_pkg::I_BIAKI];
	assign dmgiS = st_r.s2[hbdma_pkg::I_DMGI];
	assign addrS = st_r.s2[hbdma_pkg::I_ADDR +: 16];
	assign wdS = st_r.s2[hbdma_pkg::I_WD +: 8];
	assign dalS = st_r.s2[hbdma_pkg::I_DAL +: 16];
	assign pend = st_r.irqA | st_r.irqB;

	always_comb begin
		st_nxt = st_r;
		// two-stage synchroniser for every host bus and local memory bus input
		st_nxt.s1 = inVec;
		st_nxt.s2 = st_r.s1;
		if (portWr && portAddr == hbdma_pkg::PORT1_ADDR) begin
			st_nxt.irqA = portWdata[hbdma_pkg::P1_IRQA];
		end
		// upper address bit, bank select and level b request
		if (portWr && portAddr == hbdma_pkg::PORT2_ADDR) begin
			st_nxt.upper = portWdata[hbdma_pkg::P2_UPPER];
			st_nxt.bs7 = portWdata[hbdma_pkg::P2_BS7];
			st_nxt.irqB = portWdata[hbdma_pkg::P2_IRQB];
		end
		st_nxt.portRdata = 8'h00;
		if (portRd && portAddr == hbdma_pkg::PORT1_ADDR) begin
			st_nxt.portRdata[hbdma_pkg::P1_IRQA] = st_r.irqA;
			st_nxt.portRdata[hbdma_pkg::P1_BUSY] = st_r.state != hbdma_pkg::ST_IDLE;
		end
		if (portRd && portAddr == hbdma_pkg::PORT2_ADDR) begin
			st_nxt.portRdata[hbdma_pkg::P2_UPPER] = st_r.upper;
			st_nxt.portRdata[hbdma_pkg::P2_BS7] = st_r.bs7;
			st_nxt.portRdata[hbdma_pkg::P2_IRQB] = st_r.irqB;
		end
		// vector released when host drops din
		if (st_r.vecDrive) begin
			if (!dinS) begin
				st_nxt.vecDrive = 1'b0;
				st_nxt.vecRply = 1'b0;
			end
		// acknowledge, level a wins over b
		end else if (dinS && biakiS && pend && !st_r.sack) begin
			st_nxt.vecDrive = 1'b1;
			st_nxt.vecRply = 1'b1;
			st_nxt.lvlBSel = !st_r.irqA;
		end
		// request out while not being acknowledged
		st_nxt.birq = (st_nxt.irqA | st_nxt.irqB) & !st_nxt.vecDrive;
		// acknowledge passes on when nothing is pending
		st_nxt.biako = biakiS & !(st_nxt.irqA | st_nxt.irqB);
		// window decode of upper local half
		st_nxt.winHit = mreqS & addrS[hbdma_pkg::WIN_BIT];
		// grant passes on only while not requesting
		st_nxt.dmgo = dmgiS & (st_r.state == hbdma_pkg::ST_IDLE);
		if (st_r.tmoRun) begin
			st_nxt.tmo = st_r.tmo + 12'h001;
		end
		case (st_r.state)
			hbdma_pkg::ST_IDLE: begin
				// start request, stall processor, arm timer
				if (st_nxt.winHit) begin
					st_nxt.state = hbdma_pkg::ST_REQ;
					st_nxt.local_memory_request = 1'b1;
					st_nxt.ready = 1'b0;
					st_nxt.isWrite = mwrS;
					st_nxt.addr = {st_r.upper, addrS[14:0]};
					st_nxt.wdata = wdS;
					st_nxt.tmo = 12'h000;
					st_nxt.tmoRun = 1'b1;
				end
			end
			hbdma_pkg::ST_REQ: begin
				if (dmgiS) begin
					st_nxt.state = hbdma_pkg::ST_WAITBUS;
				end
			end
			hbdma_pkg::ST_WAITBUS: begin
				// take the bus once sync and reply are idle
				if (!syncS && !rplyS) begin
					st_nxt.sack = 1'b1;
					st_nxt.local_memory_request = 1'b0;
					// step 0: address, bank select, write flag
					st_nxt.addrEn = 1'b1;
					st_nxt.bs7Oe = st_r.bs7;
					st_nxt.wtbt = st_r.isWrite;
					st_nxt.stepCnt = 4'h0;
					st_nxt.step = 3'h0;
					st_nxt.state = hbdma_pkg::ST_STEP;
				end
			end
			hbdma_pkg::ST_STEP: begin
				st_nxt.stepCnt = st_r.stepCnt + 4'h1;
				if (st_r.stepCnt == hbdma_pkg::STEP_LAST) begin
					st_nxt.stepCnt = 4'h0;
					st_nxt.step = st_r.step + 3'h1;
					if (st_nxt.step == hbdma_pkg::STEP_SYNC) begin
						st_nxt.sync = 1'b1;
					end
					// address off, write data on at 440
					if (st_nxt.step == hbdma_pkg::STEP_DATA) begin
						st_nxt.addrEn = 1'b0;
						st_nxt.bs7Oe = 1'b0;
						st_nxt.dataEn = st_r.isWrite;
					end
					if (st_nxt.step == hbdma_pkg::STEP_STRB) begin
						st_nxt.dout = st_r.isWrite;
						st_nxt.din = !st_r.isWrite;
						st_nxt.state = hbdma_pkg::ST_WAITRPLY;
					end
				end
			end
			hbdma_pkg::ST_WAITRPLY: begin
				// reply frees processor, read byte lane
				if (rplyS) begin
					st_nxt.rdata = st_r.addr[0] ? dalS[15:8] : dalS[7:0];
					st_nxt.ready = 1'b1;
					st_nxt.tmoRun = 1'b0;
					st_nxt.state = hbdma_pkg::ST_HOLD;
				end
			end
			hbdma_pkg::ST_HOLD: begin
				if (!mreqS) begin
					st_nxt.din = 1'b0;
					st_nxt.dout = 1'b0;
					st_nxt.state = hbdma_pkg::ST_WAITRN;
				end
			end
			hbdma_pkg::ST_WAITRN: begin
				// trailing edge of reply starts release timer
				if (!rplyS) begin
					st_nxt.stepCnt = 4'h0;
					st_nxt.state = hbdma_pkg::ST_RESET;
				end
			end
			hbdma_pkg::ST_RESET: begin
				st_nxt.stepCnt = st_r.stepCnt + 4'h1;
				// r110 releases the bus, all back to idle
				if (st_r.stepCnt == hbdma_pkg::STEP_LAST) begin
					st_nxt.sync = 1'b0;
					st_nxt.dataEn = 1'b0;
					st_nxt.wtbt = 1'b0;
					st_nxt.sack = 1'b0;
					st_nxt.local_memory_request = 1'b0;
					st_nxt.addrEn = 1'b0;
					st_nxt.bs7Oe = 1'b0;
					st_nxt.din = 1'b0;
					st_nxt.dout = 1'b0;
					st_nxt.stepCnt = 4'h0;
					st_nxt.state = hbdma_pkg::ST_IDLE;
				end
			end
			hbdma_pkg::ST_FORCED: begin
				if (!mreqS) begin
					st_nxt.forced = 1'b0;
					st_nxt.stepCnt = 4'h0;
					st_nxt.state = hbdma_pkg::ST_RESET;
				end
			end
			default: begin
				st_nxt.state = hbdma_pkg::ST_IDLE;
			end
		endcase
		// timeout forces a reply; a reply in the same cycle wins
		if (st_nxt.tmoRun && st_r.tmo == hbdma_pkg::TMO_LAST) begin
			st_nxt.tmoRun = 1'b0;
			st_nxt.forced = 1'b1;
			st_nxt.ready = 1'b1;
			st_nxt.state = hbdma_pkg::ST_FORCED;
		end
		st_nxt.dalOe = st_nxt.addrEn | st_nxt.dataEn | st_nxt.vecDrive;
		if (st_nxt.addrEn) begin
			st_nxt.dalOut = st_nxt.addr;
		end else if (st_nxt.dataEn) begin
			st_nxt.dalOut = st_nxt.addr[0] ? {st_nxt.wdata, 8'h00} : {8'h00, st_nxt.wdata};
		end else if (st_nxt.vecDrive) begin
			st_nxt.dalOut = st_nxt.lvlBSel ? hbdma_pkg::VEC_B : hbdma_pkg::VEC_A;
		end else begin
			st_nxt.dalOut = 16'h0000;
		end
		st_nxt.hsw = 16'h0000;
		st_nxt.hsw[hbdma_pkg::HSW_IRQA] = st_nxt.irqA;
		st_nxt.hsw[hbdma_pkg::HSW_IRQB] = st_nxt.irqB;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.ready <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign portRdata = st_r.portRdata;
	assign memRdata = st_r.rdata;
	assign localReady = st_r.ready;
	assign hostDalOut = st_r.dalOut;
	assign hostDalOe = st_r.dalOe;
	assign hostBirqOe = st_r.birq;
	assign hostBiakoOut = st_r.biako;
	assign hostDmgoOut = st_r.dmgo;
	assign hostDmrOe = st_r.local_memory_request;
	assign hostSackOe = st_r.sack;
	assign hostSyncOe = st_r.sync;
	assign hostDinOe = st_r.din;
	assign hostDoutOe = st_r.dout;
	assign hostWtbtOe = st_r.wtbt;
	assign hostBs7Oe = st_r.bs7Oe;
	assign hostRplyOe = st_r.vecRply;
	assign vectorDrive = st_r.vecDrive;
	assign levelBVectorSelect = st_r.lvlBSel;
	assign dmaWindowHit = st_r.winHit;
	assign forcedReply = st_r.forced;
	assign hostStatusWord0 = st_r.hsw;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	property p_birq;
		(st_r.irqA || st_r.irqB) && !st_r.vecDrive |-> st_r.birq;
	endproperty
	a_birq: assert property (p_birq) else $error("birq missing with request pending");

	property p_vec_ack;
		$rose(st_r.vecDrive) |-> st_r.vecRply && !st_r.birq && st_r.dalOe;
	endproperty
	a_vec_ack: assert property (p_vec_ack) else $error("vector cycle incomplete");

	localparam int VEC_SEL_BIT_L = hbdma_pkg::VEC_SEL_BIT;
	property p_vec_sel;
		st_r.vecDrive |-> st_r.dalOut[VEC_SEL_BIT_L] == st_r.lvlBSel;
	endproperty
	a_vec_sel: assert property (p_vec_sel) else $error("vector line two wrong");

	property p_vec_hold;
		st_r.vecDrive && !dinS |=> !st_r.vecDrive && !st_r.vecRply;
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector not released");

	property p_window;
		st_r.state == hbdma_pkg::ST_IDLE && mreqS && addrS[15] |=> st_r.local_memory_request && !st_r.ready;
	endproperty
	a_window: assert property (p_window) else $error("window hit did not start dma");

	property p_wait;
		st_r.state == hbdma_pkg::ST_STEP || st_r.state == hbdma_pkg::ST_WAITRPLY |-> !st_r.ready;
	endproperty
	a_wait: assert property (p_wait) else $error("processor not held");

	property p_grant;
		st_r.state != hbdma_pkg::ST_IDLE |=> !st_r.dmgo;
	endproperty
	a_grant: assert property (p_grant) else $error("grant passed on while busy");

	property p_sack;
		$rose(st_r.sack) |-> !st_r.local_memory_request && !$past(syncS) && !$past(rplyS) && st_r.addrEn
			&& st_r.wtbt == st_r.isWrite;
	endproperty
	a_sack: assert property (p_sack) else $error("sack taken with bus busy");

	property p_sync_time;
		$rose(st_r.sack) |-> ##33 $rose(st_r.sync) ##11 !st_r.addrEn;
	endproperty
	a_sync_time: assert property (p_sync_time) else $error("sync or address step wrong");

	property p_strobe;
		$rose(st_r.sack) |-> ##55 (st_r.dout == st_r.isWrite) && (st_r.din == !st_r.isWrite);
	endproperty
	a_strobe: assert property (p_strobe) else $error("data strobe step wrong");

	property p_release;
		$fell(st_r.sack) |-> !st_r.sync && !st_r.dataEn && !st_r.wtbt && $past(st_r.state) == hbdma_pkg::ST_RESET;
	endproperty
	a_release: assert property (p_release) else $error("bus released badly");

	property p_tmo;
		$rose(st_r.forced) |-> $past(st_r.tmo) == hbdma_pkg::TMO_LAST && st_r.ready;
	endproperty
	a_tmo: assert property (p_tmo) else $error("forced reply at wrong time");

	property p_forced_clr;
		st_r.forced && !mreqS |=> !st_r.forced && st_r.state == hbdma_pkg::ST_RESET;
	endproperty
	a_forced_clr: assert property (p_forced_clr) else $error("forced reply not cleared");
endmodule

// File: test/hbdma_host_model.sv
// host bus far side: grant arbiter, one byte slave and interrupt acknowledger
// assumes active-high line levels; a released line reads 0 through its terminator
`timescale 1ns/1ps
module hbdma_host_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// bench control
	input wire logic ackGo,
	input wire logic mute,
	input wire logic [3:0] lag,
	// drives from the block
	input wire logic [15:0] hostDalOut,
	input wire logic hostDalOe,
	input wire logic hostDmrOe,
	input wire logic hostSackOe,
	input wire logic hostSyncOe,
	input wire logic hostDinOe,
	input wire logic hostDoutOe,
	input wire logic hostBirqOe,
	input wire logic hostBs7Oe,
	input wire logic hostRplyOe,
	// received levels
	output logic [15:0] hostDalIn,
	output logic hostSyncIn,
	output logic hostRplyIn,
	output logic hostDinIn,
	output logic hostBiakiIn,
	output logic hostDmgiIn,
	// observations
	output logic [16:0] vecSeen,
	output logic vecValid,
	output logic [16:0] slvAddr,
	output logic [15:0] slvData,
	output logic [7:0] syncGap,
	output logic [7:0] strbGap,
	output logic slvValid
);
	logic ackLvl, ackSeen, rply, drv, syncQ, strbQ, strb;
	logic [3:0] waitCnt;
	logic [7:0] gap;
	assign strb = hostDinOe | hostDoutOe;
	assign hostDalIn = hostDalOe ? hostDalOut : (drv ? {slvAddr[7:0] ^ 8'h5a, slvAddr[7:0] ^ 8'ha5} : 16'h0000);
	assign hostSyncIn = hostSyncOe;
	assign hostRplyIn = rply | hostRplyOe;
	// host acknowledge with din and biaki
	assign hostDinIn = ackLvl | hostDinOe;
	assign hostBiakiIn = ackLvl;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			{ackLvl, ackSeen, rply, drv, syncQ, strbQ, vecValid, slvValid, hostDmgiIn} <= '0;
			{vecSeen, slvAddr, slvData, syncGap, strbGap, gap, waitCnt} <= '0;
		end else begin
			vecValid <= 1'b0;
			slvValid <= 1'b0;
			syncQ <= hostSyncOe;
			strbQ <= strb;
			// grant drops once sack is seen
			hostDmgiIn <= hostDmrOe & ~hostSackOe;
			gap <= hostSackOe ? gap + 8'h01 : 8'h00;
			if (hostSyncOe && !syncQ) begin
				syncGap <= gap;
				slvAddr <= {hostBs7Oe, hostDalIn};
			end
			if (strb && !strbQ) begin
				strbGap <= gap;
				waitCnt <= lag;
			end else if (strb && !rply && !mute) begin
				// slave replies after its own delay
				if (waitCnt == 4'h0) begin
					rply <= 1'b1;
					drv <= hostDinOe;
					slvData <= hostDalIn;
					slvValid <= 1'b1;
				end else begin
					waitCnt <= waitCnt - 4'h1;
				end
			end
			if (!strb) begin
				rply <= 1'b0;
				drv <= 1'b0;
			end
			if (ackGo && !ackSeen) ackLvl <= 1'b1;
			if (ackLvl && hostRplyOe && hostDalOe) begin
				vecSeen <= {hostBirqOe, hostDalOut};
				vecValid <= 1'b1;
				ackLvl <= 1'b0;
				ackSeen <= 1'b1;
			end
			if (!ackGo) begin
				ackLvl <= 1'b0;
				ackSeen <= 1'b0;
			end
		end
	end
endmodule

// File: test/tb_hbdma_bridge.sv
// self-checking bench: port writes, interrupt acknowledges, dma reads, writes, timeout
// assumes the host model answers on the far side of the bridge
`timescale 1ns/1ps
module tb_hbdma_bridge;
	logic core_clk, reset_n, portWr, portRd, memReq, memWrite, ackGo, mute, rdQ, rdyQ;
	logic [7:0] portAddr, portWdata, portRdata, memWdata, memRdata, syncGap, strbGap;
	logic [15:0] memAddr, hostDalIn, hostDalOut, hostStatusWord0, slvData;
	logic hostSyncIn, hostRplyIn, hostDinIn, hostBiakiIn, hostDmgiIn, localReady, hostDalOe, hostBirqOe;
	logic hostBiakoOut, hostDmgoOut, hostDmrOe, hostSackOe, hostSyncOe, hostDinOe, hostDoutOe, hostWtbtOe;
	logic hostBs7Oe, hostRplyOe, vectorDrive, levelBVectorSelect, dmaWindowHit, forcedReply, vecValid, slvValid;
	logic [3:0] lag;
	logic [16:0] vecSeen, slvAddr;
	logic [25:0] e;
	logic [7:0] portQ[$];
	logic [7:0] memQ[$];
	logic [16:0] vecQ[$];
	logic [25:0] slvQ[$];
	int errTotal = 0, nChecks = 0, cyc = 0, seed = 15942;

	hbdma_bridge hbdma_bridge_i (.core_clk(core_clk), .reset_n(reset_n), .portAddr(portAddr),
		.portWdata(portWdata), .portWr(portWr), .portRd(portRd), .portRdata(portRdata), .memAddr(memAddr),
		.memWdata(memWdata), .memReq(memReq), .memWrite(memWrite), .memRdata(memRdata),
		.localReady(localReady), .hostDalIn(hostDalIn), .hostSyncIn(hostSyncIn), .hostRplyIn(hostRplyIn),
		.hostDinIn(hostDinIn), .hostBiakiIn(hostBiakiIn), .hostDmgiIn(hostDmgiIn), .hostDalOut(hostDalOut),
		.hostDalOe(hostDalOe), .hostBirqOe(hostBirqOe), .hostBiakoOut(hostBiakoOut),
		.hostDmgoOut(hostDmgoOut), .hostDmrOe(hostDmrOe), .hostSackOe(hostSackOe), .hostSyncOe(hostSyncOe),
		.hostDinOe(hostDinOe), .hostDoutOe(hostDoutOe), .hostWtbtOe(hostWtbtOe), .hostBs7Oe(hostBs7Oe),
		.hostRplyOe(hostRplyOe), .vectorDrive(vectorDrive), .levelBVectorSelect(levelBVectorSelect),
		.dmaWindowHit(dmaWindowHit), .forcedReply(forcedReply), .hostStatusWord0(hostStatusWord0));

	hbdma_host_model hbdma_host_model_i (.core_clk(core_clk), .reset_n(reset_n), .ackGo(ackGo),
		.mute(mute), .lag(lag), .hostDalOut(hostDalOut), .hostDalOe(hostDalOe), .hostDmrOe(hostDmrOe),
		.hostSackOe(hostSackOe), .hostSyncOe(hostSyncOe), .hostDinOe(hostDinOe), .hostDoutOe(hostDoutOe),
		.hostBirqOe(hostBirqOe), .hostBs7Oe(hostBs7Oe), .hostRplyOe(hostRplyOe), .hostDalIn(hostDalIn),
		.hostSyncIn(hostSyncIn), .hostRplyIn(hostRplyIn), .hostDinIn(hostDinIn), .hostBiakiIn(hostBiakiIn),
		.hostDmgiIn(hostDmgiIn), .vecSeen(vecSeen), .vecValid(vecValid), .slvAddr(slvAddr),
		.slvData(slvData), .syncGap(syncGap), .strbGap(strbGap), .slvValid(slvValid));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic wrapUp();
		$display("checks %0d errors %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		nChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic pw(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		portAddr <= a;
		portWdata <= d;
		portWr <= 1'b1;
		@(posedge core_clk);
		portWr <= 1'b0;
	endtask

	task automatic pr(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		portAddr <= a;
		portRd <= 1'b1;
		portQ.push_back(exp);
		@(posedge core_clk);
		portRd <= 1'b0;
	endtask

	task automatic ack(input logic on, input logic [15:0] vec);
		int n;
		n = 0;
		@(posedge core_clk);
		ackGo <= 1'b1;
		if (on) vecQ.push_back({1'b0, vec});
		while (on && vecValid !== 1'b1 && n < 30) begin
			@(posedge core_clk);
			n++;
		end
		if (!on) repeat (8) @(posedge core_clk);
		if (on) chk("vecSel", vec[hbdma_pkg::VEC_SEL_BIT], levelBVectorSelect);
		chk("biako", !on, hostBiakoOut);
		chk("ackWait", 1, n < 30);
		ackGo <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk("vectorDrive", 0, {vectorDrive, hostDalOe, hostRplyOe});
	endtask

	task automatic dma(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic [1:0] sel);
		int n;
		n = 0;
		@(posedge core_clk);
		{memAddr, memWdata, memWrite, memReq} <= {a, d, wr, 1'b1};
		if (!mute && a[15]) slvQ.push_back({wr, sel[1], sel[0], a[14:0], d});
		if (!mute && !wr && a[15]) memQ.push_back(a[0] ? a[7:0] ^ 8'h5a : a[7:0] ^ 8'ha5);
		while (localReady !== 1'b0 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		chk("waitState", !a[15], localReady);
		chk("windowHit", a[15], dmaWindowHit);
		chk("dmaRequest", a[15], hostDmrOe);
		repeat (5) @(posedge core_clk);
		chk("grantOut", 0, hostDmgoOut);
		while (localReady !== 1'b1 && n < 6000) begin
			@(posedge core_clk);
			n++;
		end
		chk("readyBack", 1, localReady);
		chk("forcedReply", mute, forcedReply);
		memReq <= 1'b0;
		repeat (40) @(posedge core_clk);
		chk("idle", 0, {forcedReply, hostSackOe, hostSyncOe, hostDinOe, hostDoutOe, hostWtbtOe});
	endtask

	always @(posedge core_clk) begin
		if (rdQ) chk("portRdata", portQ.pop_front(), portRdata);
		rdQ <= portRd;
		if (vecValid) chk("vector", vecQ.pop_front(), vecSeen);
		if (localReady && !rdyQ && memQ.size() > 0) chk("memRdata", memQ.pop_front(), memRdata);
		rdyQ <= localReady;
		if (slvValid) begin
			e = slvQ.pop_front();
			chk("hostAddr", e[24:8], slvAddr);
			chk("syncGap", hbdma_pkg::STEP_SYNC * hbdma_pkg::STEP_CYC, syncGap);
			chk("strbGap", hbdma_pkg::STEP_STRB * hbdma_pkg::STEP_CYC, strbGap);
			if (e[25]) chk("hostData", e[7:0], slvAddr[0] ? slvData[15:8] : slvData[7:0]);
		end
		cyc++;
		if (cyc == 20000) begin
			errTotal++;
			wrapUp();
		end
	end

	initial begin
		{reset_n, portWr, portRd, memReq, memWrite, ackGo, mute} = '0;
		{portAddr, portWdata, memWdata, memAddr, lag} = '0;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		// interrupt levels: none, a, b, both
		for (int i = 0; i < 4; i++) begin
			pw(8'h01, {7'h00, i[0]});
			pw(8'h02, {3'h0, i[1], 4'h0});
			repeat (2) @(posedge core_clk);
			chk("birq", i[0] | i[1], hostBirqOe);
			chk("hsw0", {6'h00, i[1], i[0], 8'h00}, hostStatusWord0);
			pr(8'h01, {7'h00, i[0]});
			pr(8'h02, {3'h0, i[1], 4'h0});
			ack(i[0] | i[1], i[0] ? hbdma_pkg::VEC_A : hbdma_pkg::VEC_B);
		end
		pw(8'h01, 8'h00);
		pr(8'h05, 8'h00);
		// outside the window nothing starts
		dma(1'b0, 16'h1234, 8'h00, 2'h0);
		// each host half and bank, reads and writes
		for (int i = 0; i < 8; i++) begin
			pw(8'h02, {4'h0, i[1], 2'h0, i[0]});
			lag <= 4'($random(seed)) & 4'h7;
			dma(i[2], {1'b1, 15'($random(seed))}, 8'($random(seed)), i[1:0]);
		end
		mute <= 1'b1;
		dma(1'b1, 16'h8001, 8'h3c, 2'h0);
		mute <= 1'b0;
		dma(1'b0, 16'hfffe, 8'h00, 2'h3);
		wrapUp();
	end
endmodule
